// File: twst_slave_tx.sv
// slave transmitter and miscellaneous status logic of the two-wire interface with an apb register port
`timescale 1ns/1ps
`include "twst_regs.svh"
module twst_slave_tx (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // two-wire pins, open drain: oe high pulls the line low
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe,
   output logic sda_o,
   output logic sda_oe,
   // neighbouring master and receiver logic
   input wire logic arb_lost_i,
   output logic start_gen_o,
   output logic slave_receive_o
);
   twst_pkg::twst_all_t r_r;
   twst_pkg::twst_all_t r_nxt;

   function automatic logic [7:0] status_byte(input logic flag, input logic [7:0] code, input logic [1:0] presc);
      logic [7:0] v;
      v = flag ? code : `TWST_CODE_IDLE;
      status_byte = {v[7:3], 1'b0, presc};
   endfunction

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic acc;
   logic wr;
   logic clr;
   logic in_frame;

   always_comb begin
      scl_rise = r_r.scl_s[1] && !r_r.scl_s[2];
      scl_fall = !r_r.scl_s[1] && r_r.scl_s[2];
      bus_start = r_r.scl_s[1] && r_r.scl_s[2] && !r_r.sda_s[1] && r_r.sda_s[2];
      bus_stop = r_r.scl_s[1] && r_r.scl_s[2] && r_r.sda_s[1] && !r_r.sda_s[2];
      acc = psel && penable && r_r.pready;
      wr = acc && pwrite && (paddr == `TWST_OFF_CTRL);
      clr = wr && pwdata[`TWST_CTRL_FLAG] && r_r.ctrl.flag;
      in_frame = (r_r.st == twst_pkg::ST_ADDR && r_r.cnt != 4'h0) || r_r.st == twst_pkg::ST_AACK ||
                 r_r.st == twst_pkg::ST_TX || r_r.st == twst_pkg::ST_TACK || r_r.st == twst_pkg::ST_AEND;
   end

   always_comb begin
      logic set_flag;
      set_flag = 1'b0;
      r_nxt = r_r;
      r_nxt.scl_s = {r_r.scl_s[1:0], scl_i};
      r_nxt.sda_s = {r_r.sda_s[1:0], sda_i};
      r_nxt.start_gen = 1'b0;

      // apb: one wait state, read data registered in the first access cycle
      r_nxt.pready = psel && penable && !r_r.pready;
      if (psel && penable && !r_r.pready) begin
         r_nxt.pslverr = 1'b0;
         case (paddr)
            `TWST_OFF_CTRL: r_nxt.prdata = {24'h000000, r_r.ctrl.flag, r_r.ctrl.ack_en, r_r.ctrl.start_request_bit,
                                            r_r.ctrl.stop_request_bit, 1'b0, r_r.ctrl.en, 2'b00};
            `TWST_OFF_STATUS: r_nxt.prdata = {24'h000000, status_byte(r_r.ctrl.flag, r_r.code, r_r.presc)};
            `TWST_OFF_DATA: r_nxt.prdata = {24'h000000, r_r.data};
            `TWST_OFF_ADDR: r_nxt.prdata = {24'h000000, r_r.own, r_r.gce};
            default: begin
               r_nxt.prdata = 32'h00000000;
               r_nxt.pslverr = 1'b1;
            end
         endcase
      end
      if (acc && pwrite) begin
         case (paddr)
            `TWST_OFF_CTRL: begin
               r_nxt.ctrl.ack_en = pwdata[`TWST_CTRL_ACKEN];
               r_nxt.ctrl.start_request_bit = pwdata[`TWST_CTRL_STA];
               r_nxt.ctrl.stop_request_bit = pwdata[`TWST_CTRL_STO];
               r_nxt.ctrl.en = pwdata[`TWST_CTRL_EN];
            end
            `TWST_OFF_STATUS: r_nxt.presc = pwdata[1:0];
            `TWST_OFF_DATA: r_nxt.data = pwdata[7:0];
            `TWST_OFF_ADDR: begin
               r_nxt.own = pwdata[7:1];
               r_nxt.gce = pwdata[0];
            end
            default: r_nxt.presc = r_r.presc;
         endcase
      end

      if (bus_start) begin
         r_nxt.busy = 1'b1;
      end
      if (bus_stop) begin
         r_nxt.busy = 1'b0;
         r_nxt.srx = 1'b0;
      end
      if (r_r.start_pend && !r_r.busy) begin
         r_nxt.start_gen = 1'b1;
         r_nxt.start_pend = 1'b0;
      end

      case (r_r.st)
         twst_pkg::ST_IDLE: begin
            r_nxt.sda_oe = 1'b0;
            r_nxt.scl_oe = 1'b0;
            if (bus_start && r_r.ctrl.en) begin
               r_nxt.st = twst_pkg::ST_ADDR;
               r_nxt.cnt = 4'h0;
               r_nxt.srx = 1'b0;
            end
         end
         twst_pkg::ST_ADDR: begin
            if (scl_rise) begin
               r_nxt.sh = {r_r.sh[6:0], r_r.sda_s[1]};
               r_nxt.cnt = r_r.cnt + 4'h1;
            end else if (scl_fall && r_r.cnt == `TWST_BYTE_BITS) begin
               // recognition only while ack enable is high
               if (r_r.ctrl.ack_en && r_r.sh[7:1] == r_r.own && r_r.sh[0]) begin
                  r_nxt.st = twst_pkg::ST_AACK;
                  r_nxt.sda_oe = 1'b1;
                  r_nxt.code = arb_lost_i ? `TWST_CODE_ARB_R : `TWST_CODE_SLA_R;
               end else begin
                  if (r_r.ctrl.ack_en && !r_r.sh[0] &&
                      (r_r.sh[7:1] == r_r.own || (r_r.gce && r_r.sh[7:1] == 7'h00))) begin
                     r_nxt.srx = 1'b1;
                  end
                  r_nxt.st = twst_pkg::ST_IDLE;
               end
            end
         end
         twst_pkg::ST_AACK: begin
            if (scl_fall) begin
               r_nxt.sda_oe = 1'b0;
               r_nxt.scl_oe = 1'b1;
               r_nxt.st = twst_pkg::ST_WAIT;
               set_flag = 1'b1;
            end
         end
         twst_pkg::ST_WAIT: begin
            r_nxt.scl_oe = 1'b1;
            if (clr) begin
               if (r_r.code == `TWST_CODE_DATA_NACK || r_r.code == `TWST_CODE_LAST_ACK) begin
                  r_nxt.st = twst_pkg::ST_IDLE;
                  r_nxt.scl_oe = 1'b0;
                  r_nxt.sda_oe = 1'b0;
                  r_nxt.start_pend = pwdata[`TWST_CTRL_STA];
               end else begin
                  r_nxt.st = twst_pkg::ST_TX;
                  r_nxt.sh = r_r.data;
                  r_nxt.cnt = 4'h0;
                  r_nxt.last = !pwdata[`TWST_CTRL_ACKEN];
                  r_nxt.sda_oe = !r_r.data[7];
                  r_nxt.scl_oe = 1'b0;
               end
            end
         end
         twst_pkg::ST_TX: begin
            if (scl_fall) begin
               if (r_r.cnt == `TWST_BYTE_BITS - 4'h1) begin
                  r_nxt.st = twst_pkg::ST_TACK;
                  r_nxt.sda_oe = 1'b0;
               end else begin
                  r_nxt.sh = {r_r.sh[6:0], 1'b1};
                  r_nxt.sda_oe = !r_r.sh[6];
                  r_nxt.cnt = r_r.cnt + 4'h1;
               end
            end
         end
         twst_pkg::ST_TACK: begin
            if (scl_rise) begin
               r_nxt.st = twst_pkg::ST_AEND;
               if (r_r.sda_s[1]) begin
                  r_nxt.code = `TWST_CODE_DATA_NACK;
               end else if (r_r.last) begin
                  r_nxt.code = `TWST_CODE_LAST_ACK;
               end else begin
                  r_nxt.code = `TWST_CODE_DATA_ACK;
               end
            end
         end
         twst_pkg::ST_AEND: begin
            if (scl_fall) begin
               r_nxt.scl_oe = 1'b1;
               r_nxt.st = twst_pkg::ST_WAIT;
               set_flag = 1'b1;
            end
         end
         twst_pkg::ST_ERR: begin
            r_nxt.sda_oe = 1'b0;
            r_nxt.scl_oe = 1'b0;
            if (clr && pwdata[`TWST_CTRL_STO]) begin
               r_nxt.st = twst_pkg::ST_IDLE;
               r_nxt.ctrl.stop_request_bit = 1'b0;
            end
         end
         default: r_nxt.st = twst_pkg::ST_IDLE;
      endcase

      if ((bus_start || bus_stop) && in_frame) begin
         r_nxt.st = twst_pkg::ST_ERR;
         r_nxt.code = `TWST_CODE_BUSERR;
         r_nxt.sda_oe = 1'b0;
         r_nxt.scl_oe = 1'b0;
         set_flag = 1'b1;
      end
      if (!r_r.ctrl.en) begin
         r_nxt.st = twst_pkg::ST_IDLE;
         r_nxt.sda_oe = 1'b0;
         r_nxt.scl_oe = 1'b0;
      end

      // a hardware set wins over a software clear in the same cycle
      if (set_flag) begin
         r_nxt.ctrl.flag = 1'b1;
      end else if (clr) begin
         r_nxt.ctrl.flag = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '0;
         r_r.st <= twst_pkg::ST_IDLE;
         r_r.ctrl <= 5'(`TWST_CTRL_RST);
         r_r.data <= `TWST_DATA_RST;
         r_r.own <= 7'h00;
         r_r.code <= `TWST_CODE_IDLE;
         r_r.scl_s <= 3'b111;
         r_r.sda_s <= 3'b111;
      end else begin
         r_r <= r_nxt;
      end
   end

   always_comb begin
      prdata = r_r.prdata;
      pready = r_r.pready;
      pslverr = r_r.pslverr && r_r.pready;
      scl_o = 1'b0;
      sda_o = 1'b0;
      scl_oe = r_r.scl_oe;
      sda_oe = r_r.sda_oe;
      start_gen_o = r_r.start_gen;
      slave_receive_o = r_r.srx;
   end
endmodule

// File: twst_regs.svh
// register map, field positions, reset values and status codes of the slave transmitter block
// Function
// - own address with read bit acknowledged: set flag, status 0xa8
// - arbitration lost then addressed for read: acknowledge, set flag, status 0xb0
// - data byte sent and acknowledged: set flag, status 0xb8
// - flag cleared with ack enable low: send byte as final, expect no acknowledge
// - flag cleared with ack enable high: send byte, expect acknowledge
// - data byte answered with no acknowledge: set flag, status 0xc0
// - final byte acknowledged anyway: set flag, status 0xc8
// - clear in 0xc0/0xc8, ack enable low: unaddressed, ignore own and general call
// - clear in 0xc0/0xc8, ack enable high: own address seen, general call if enabled
// - start request set at that clear: issue start once bus is free
// - flag clear means status 0xf8
// - start or stop inside address, data or acknowledge is a bus error, status 0x00
// - bus error sets the flag
// - recovery enters unaddressed mode, clears only the stop request
// - recovery releases both lines and sends no stop
// - read direction gives slave transmitter, write gives slave receiver
// - own address in upper seven bits, lsb enables general call
// - after final byte the master is ignored and reads all ones
`ifndef TWST_REGS_SVH
`define TWST_REGS_SVH
`define TWST_OFF_CTRL 12'h000
`define TWST_OFF_STATUS 12'h004
`define TWST_OFF_DATA 12'h008
`define TWST_OFF_ADDR 12'h00c
`define TWST_CTRL_FLAG 7
`define TWST_CTRL_ACKEN 6
`define TWST_CTRL_STA 5
`define TWST_CTRL_STO 4
`define TWST_CTRL_EN 2
`define TWST_CTRL_RST 8'h00
`define TWST_ADDR_RST 8'h00
`define TWST_DATA_RST 8'hff
`define TWST_CODE_SLA_R 8'ha8
`define TWST_CODE_ARB_R 8'hb0
`define TWST_CODE_DATA_ACK 8'hb8
`define TWST_CODE_DATA_NACK 8'hc0
`define TWST_CODE_LAST_ACK 8'hc8
`define TWST_CODE_IDLE 8'hf8
`define TWST_CODE_BUSERR 8'h00
`define TWST_BYTE_BITS 4'h8
`endif

// File: twst_pkg.sv
// types of the slave transmitter block
package twst_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b010,
      ST_TX = 3'b011,
      ST_TACK = 3'b100,
      ST_AEND = 3'b101,
      ST_WAIT = 3'b110,
      ST_ERR = 3'b111
   } twst_state_t;

   typedef struct packed {
      logic flag;
      logic ack_en;
      logic start_request_bit;
      logic stop_request_bit;
      logic en;
   } twst_ctrl_t;

   typedef struct packed {
      twst_state_t st;
      twst_ctrl_t ctrl;
      logic [1:0] presc;
      logic [7:0] data;
      logic [6:0] own;
      logic gce;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] code;
      logic last;
      logic busy;
      logic start_pend;
      logic start_gen;
      logic srx;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic sda_oe;
      logic scl_oe;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } twst_all_t;
endpackage

// File: twst_asserts.sv
// port checks of the slave transmitter
`timescale 1ns/1ps
module twst_asserts (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pwrite,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // two-wire
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic start_gen_o
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ONE_WAIT: assert property ($rose(penable) |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_SLVERR: assert property (pready |-> pslverr == (paddr > 12'h00c || paddr[1:0] != 2'h0))
      else $error("pslverr does not match address");
   AST_CODE: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:8] == 24'h0 &&
      !prdata[2] && {prdata[7:3], 3'h0} inside {8'ha8, 8'hb0, 8'hb8, 8'hc0, 8'hc8, 8'hf8, 8'h00})
      else $error("status code outside the legal set");
   AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
      else $error("pin drives a high level");
   AST_START_PULSE: assert property (start_gen_o |=> !start_gen_o)
      else $error("start request longer than one cycle");
   AST_DATA_EDGE: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data line moved while clock high");
   AST_STRETCH: assert property (scl_oe |-> !sda_oe)
      else $error("data held while clock stretched");
endmodule
bind twst_slave_tx twst_asserts u_chk (.pclk, .presetn, .pwrite, .penable, .paddr, .prdata, .pready,
   .pslverr, .scl_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .start_gen_o);

// File: twst_bus_master.sv
// behavioural two-wire master receiver
`timescale 1ns/1ps
module twst_bus_master (
   // resolved lines
   input wire logic scl,
   input wire logic sda,
   // pulls, high drives low
   output logic scl_pull,
   output logic sda_pull,
   output logic stuck
);
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      stuck = 1'b0;
   end
   // release clock, honour stretching, then wait half a high phase
   task automatic scl_up();
      int i;
      scl_pull = 1'b0;
      for (i = 0; i < 4000 && scl !== 1'b1; i++)
         #10;
      if (scl !== 1'b1)
         stuck = 1'b1;
      #40;
   endtask
   task automatic clk_bit(input logic b, output logic s);
      sda_pull = !b;
      #80;
      scl_up();
      s = sda;
      #40;
      scl_pull = 1'b1;
   endtask
   task automatic start_c();
      sda_pull = 1'b0;
      #87;
      scl_up();
      sda_pull = 1'b1;
      #40;
      scl_pull = 1'b1;
   endtask
   task automatic stop_c();
      sda_pull = 1'b1;
      #80;
      scl_up();
      sda_pull = 1'b0;
      #80;
   endtask
   task automatic xfer(input logic [7:0] b, input int n, input logic ackv, output logic [7:0] q, output logic a);
      int i;
      q = 8'hff;
      a = 1'b1;
      for (i = 7; i > 7 - n; i--)
         clk_bit(b[i], q[i]);
      if (n == 8)
         clk_bit(ackv, a);
   endtask
endmodule

// File: test_twst_slave_tx.sv
// self-checking bench of the slave transmitter
`timescale 1ns/1ps
`include "twst_regs.svh"
module test_twst_slave_tx;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic arb_lost_i = 1'b0;
   logic sg_seen = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, start_gen_o, slave_receive_o;
   logic scl_pull, sda_pull, stuck, last_err;
   int err_count = 0;
   int num_checks = 0;
   wire logic scl_i = !(scl_pull | scl_oe);
   wire logic sda_i = !(sda_pull | sda_oe);
   always #10 pclk = ~pclk;
   always @(posedge pclk) if (start_gen_o === 1'b1) sg_seen <= 1'b1;
   twst_slave_tx u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .scl_i, .sda_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .arb_lost_i, .start_gen_o, .slave_receive_o);
   twst_bus_master u_mst (.scl(scl_i), .sda(sda_i), .scl_pull, .sda_pull, .stuck);
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // look at the registered answer mid-cycle, where it has settled
      @(negedge pclk);
      for (i = 0; i < 20 && pready !== 1'b1; i++)
         @(negedge pclk);
      if (pready !== 1'b1) begin
         err_count++;
         close_out();
      end
      q = prdata;
      last_err = pslverr;
      // the completing edge, with pready sampled high
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      apb(1'b1, a, {24'h0, d}, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q, {24'h0, e});
   endtask
   task automatic wait_flag(input logic [7:0] e);
      int i;
      logic [31:0] q;
      q = 32'hf8;
      for (i = 0; i < 200 && q === 32'hf8; i++)
         apb(1'b0, `TWST_OFF_STATUS, 32'h0, q);
      chk(q & 32'hfffffffc, {24'h0, e});
      if (i == 200)
         close_out();
   endtask
   // ctrl values: 44 ack+en, c4 clear+ack+en, 84 clear+en, e4 adds start, d4 adds stop
   initial begin
      logic [7:0] q8;
      logic a;
      int i;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TWST_OFF_CTRL, `TWST_CTRL_RST);
      rd(`TWST_OFF_STATUS, 8'hf8);
      rd(`TWST_OFF_DATA, `TWST_DATA_RST);
      rd(`TWST_OFF_ADDR, `TWST_ADDR_RST);
      wr(12'h010, 8'h12);
      chk({31'h0, last_err}, 32'h1);
      $display("reset test done");
      wr(`TWST_OFF_ADDR, 8'h6b);
      wr(`TWST_OFF_CTRL, 8'h44);
      u_mst.start_c();
      u_mst.xfer(8'h6b, 8, 1'b1, q8, a);
      chk({31'h0, a}, 32'h0);
      wait_flag(8'ha8);
      wr(`TWST_OFF_DATA, 8'h5a);
      wr(`TWST_OFF_CTRL, 8'hc4);
      u_mst.xfer(8'hff, 8, 1'b0, q8, a);
      chk({24'h0, q8}, 32'h5a);
      wait_flag(8'hb8);
      wr(`TWST_OFF_DATA, 8'h3c);
      wr(`TWST_OFF_CTRL, 8'h84);
      u_mst.xfer(8'hff, 8, 1'b0, q8, a);
      chk({24'h0, q8}, 32'h3c);
      wait_flag(8'hc8);
      wr(`TWST_OFF_CTRL, 8'he4);
      rd(`TWST_OFF_STATUS, 8'hf8);
      u_mst.xfer(8'hff, 8, 1'b0, q8, a);
      chk({24'h0, q8}, 32'hff);
      chk({31'h0, sg_seen}, 32'h0);
      u_mst.stop_c();
      for (i = 0; i < 50 && sg_seen !== 1'b1; i++)
         @(posedge pclk);
      chk({31'h0, sg_seen}, 32'h1);
      $display("ack and last byte test done");
      @(posedge pclk);
      arb_lost_i <= 1'b1;
      u_mst.start_c();
      u_mst.xfer(8'h6b, 8, 1'b1, q8, a);
      chk({31'h0, a}, 32'h0);
      wait_flag(8'hb0);
      arb_lost_i <= 1'b0;
      wr(`TWST_OFF_DATA, 8'ha5);
      wr(`TWST_OFF_CTRL, 8'h84);
      u_mst.xfer(8'hff, 8, 1'b1, q8, a);
      chk({24'h0, q8}, 32'ha5);
      wait_flag(8'hc0);
      wr(`TWST_OFF_CTRL, 8'h84);
      u_mst.stop_c();
      u_mst.start_c();
      u_mst.xfer(8'h6b, 8, 1'b1, q8, a);
      chk({31'h0, a}, 32'h1);
      u_mst.stop_c();
      $display("arbitration and no ack test done");
      wr(`TWST_OFF_CTRL, 8'h44);
      u_mst.start_c();
      u_mst.xfer(8'h6b, 3, 1'b1, q8, a);
      u_mst.start_c();
      wait_flag(8'h00);
      rd(`TWST_OFF_CTRL, 8'hc4);
      wr(`TWST_OFF_CTRL, 8'hd4);
      rd(`TWST_OFF_CTRL, 8'h44);
      chk({30'h0, sda_oe, scl_oe}, 32'h0);
      rd(`TWST_OFF_STATUS, 8'hf8);
      u_mst.stop_c();
      u_mst.start_c();
      u_mst.xfer(8'h6a, 8, 1'b1, q8, a);
      @(posedge pclk);
      chk({31'h0, slave_receive_o}, 32'h1);
      u_mst.stop_c();
      chk({31'h0, stuck}, 32'h0);
      $display("bus error and write direction test done");
      close_out();
   end
endmodule
